// ===== hw/fpp_protect.sv
// Flash program memory protection: config load, write key, access filter
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
// Functional notes
// - Code limit low byte from E5FC, high two bits from E5FE at reset.
// - Unsecured, limit not 3FF: block writes from limit*128 to 1FFFF.
// - Range C000-FFFF is never covered by code-area protection.
// - Overlap of code and boot areas follows the boot-area rule.
// - Write security on: whole program memory write protected unless override pin high.
// - New limits act only after the next reset.
// - Code byte writable in programming/test, or by byte write from boot area code outside its last 4 bytes.
// - Boot area disabled: code byte not writable in internal run.
// - Boot byte loaded from E5FD; writable only in programming/test.
// - Unsecured, boot limit not 7F: block 0 to limit*128+127.
// - Boot control: read-only byte, bit 7 reserved, 6:0 limit.
// - Code control: read-only word, 15:13 blank field, 9:0 limit.
// - Blank field set and pins all high: start in programming.
// - Security byte from E5FF: 7:4 write field, 3:0 read field.
// - Security field enabled for 0000,0001,0010,0100,1000 only.
// - Read security: reads zero outside internal run; guarded erases.
// - Write security, no override: writes and erases are dropped.
// - Key 6A must precede each program write; write needs key.
// - Any other write clears key, except another correct key write.
// - Key register reads FF; reset clears the key.
// - Test mode gives pins direct array access, bypassing the core.
// - Override pin suspends read and write security.
// - Enabled security cannot be disabled until reloaded at reset.
module fpp_protect
    import fpp_pkg::*;
#(
    parameter int ADDR_W = 17
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Environment pins
    input wire logic [1:0] i_env_select,
    input wire logic i_security_override_pin,
    input wire logic i_test_mode,
    // Core request and pin test request
    input wire fpp_req_type i_core_req,
    input wire fpp_req_type i_pin_req,
    // Flash array
    output fpp_flash_type o_flash_req,
    input wire logic [7:0] i_flash_rdata,
    input wire logic [15:0] i_flash_rdata_w,
    // Core read data and status
    output logic [15:0] o_core_rdata,
    output logic o_core_blocked,
    output logic o_ready,
    output fpp_env_type o_env
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed
    {
        fpp_state_type st;
        logic [6:0] boot_limit;
        logic [9:0] code_limit;
        logic [2:0] empty;
        logic [7:0] sec;
        fpp_env_type env;
        logic key_set;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        fpp_flash_type flash;
        logic [15:0] core_rdata;
        logic blocked;
        logic ready;
        logic blocked_seen;
    } fpp_state_reg_type;

    fpp_state_reg_type state_r;
    fpp_state_reg_type state_nxt;

    // Security field decode
    function automatic logic sec_on(input logic [3:0] f);
        sec_on = (f == 4'h0) || (f == 4'h1) || (f == 4'h2) ||
            (f == 4'h4) || (f == 4'h8);
    endfunction

    logic rd_sec;
    logic wr_sec;
    logic rd_lock;
    logic wr_lock;
    logic [16:0] code_lo;
    logic [16:0] boot_hi;
    logic in_hole;
    logic in_code;
    logic in_boot;
    logic in_odd_cfg;
    logic pc_in_boot;
    logic cfg_ok;
    logic allow;
    logic apb_acc;
    logic key_wr;
    fpp_req_type rq;

    ////////////////////////////////////////////////////////////////////////
    // Protection decode, same cycle as the request
    always_comb
    begin
        rq = i_test_mode ? i_pin_req : i_core_req;
        rd_sec = sec_on(state_r.sec[3:0]);
        wr_sec = sec_on(state_r.sec[7:4]);
        rd_lock = rd_sec && !i_security_override_pin;
        wr_lock = wr_sec && !i_security_override_pin;
        code_lo = {state_r.code_limit, 7'b000_0000};
        boot_hi = {3'b000, state_r.boot_limit, 7'b000_0000} | BOOT_TAIL;
        in_hole = (rq.addr >= HOLE_LO) && (rq.addr <= HOLE_HI);
        in_code = (state_r.code_limit != CODE_OFF) && !in_hole &&
            (rq.addr >= code_lo) && (rq.addr <= PROG_TOP);
        in_boot = (state_r.boot_limit != BOOT_OFF) &&
            (rq.addr <= boot_hi);
        pc_in_boot = (state_r.boot_limit != BOOT_OFF) &&
            (rq.pc <= (boot_hi - BOOT_LAST_WORDS));
        in_odd_cfg = rq.addr[0] && (rq.addr >= CFG_ODD_LO) &&
            (rq.addr <= CFG_SEC);
        // Config bytes: environment gates them first
        cfg_ok = 1'b1;
        if (rq.addr == CFG_CODE_LO || rq.addr == CFG_CODE_HI)
        begin
            // Boot-area code may patch it in run mode
            cfg_ok = (state_r.env != ENV_INTERNAL_RUN) ||
                (rq.byte_op && pc_in_boot);
        end
        else if (rq.addr == CFG_BOOT || rq.addr == CFG_SEC)
        begin
            cfg_ok = (state_r.env != ENV_INTERNAL_RUN);
        end
        allow = 1'b1;
        if (rq.write || rq.erase || rq.mass)
        begin
            allow = state_r.key_set && cfg_ok;
            if (wr_lock)
            begin
                allow = 1'b0;
            end
            // Boot area checked alongside code area; either blocks
            if (in_boot || in_code)
            begin
                allow = 1'b0;
            end
            if ((rq.mass || (rq.erase && in_odd_cfg)) && rd_lock)
            begin
                allow = 1'b0;
            end
        end
        apb_acc = i_psel && i_penable && !state_r.pready;
        key_wr = apb_acc && i_pwrite && (i_paddr == OFS_WRITE_KEY) &&
            (i_pwdata[7:0] == KEY_VALUE);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.pready = 1'b0;
        state_nxt.pslverr = 1'b0;
        state_nxt.flash = '0;
        state_nxt.blocked = 1'b0;
        // Reset-time configuration load; limits latched only here
        case (state_r.st)
            ST_LOAD_HI:
            begin
                state_nxt.flash.valid = 1'b1;
                state_nxt.flash.byte_op = 1'b1;
                state_nxt.flash.addr = CFG_CODE_HI;
                state_nxt.st = ST_LOAD_SEC;
            end
            ST_LOAD_SEC:
            begin
                state_nxt.code_limit[9:8] =
                    i_flash_rdata[CODE_HI_BITS-1:0];
                state_nxt.empty = i_flash_rdata[7:5];
                state_nxt.flash.valid = 1'b1;
                state_nxt.flash.byte_op = 1'b1;
                state_nxt.flash.addr = CFG_SEC;
                state_nxt.st = ST_LOAD_LO;
            end
            ST_LOAD_LO:
            begin
                state_nxt.sec = i_flash_rdata;
                state_nxt.flash.valid = 1'b1;
                state_nxt.flash.byte_op = 1'b1;
                state_nxt.flash.addr = CFG_CODE_LO;
                state_nxt.st = ST_LOAD_BOOT;
            end
            ST_LOAD_BOOT:
            begin
                state_nxt.code_limit[7:0] = i_flash_rdata;
                state_nxt.flash.valid = 1'b1;
                state_nxt.flash.byte_op = 1'b1;
                state_nxt.flash.addr = CFG_BOOT;
                state_nxt.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (!state_r.ready)
                begin
                    state_nxt.boot_limit = i_flash_rdata[6:0];
                    state_nxt.ready = 1'b1;
                    // Blank array with all pins high: programming
                    if (i_test_mode)
                    begin
                        state_nxt.env = ENV_TEST;
                    end
                    else if ((&i_env_select) &&
                        ((state_r.empty == 3'b011) ||
                        (state_r.empty == 3'b101) ||
                        (state_r.empty[2:1] == 2'b11)))
                    begin
                        state_nxt.env = ENV_PROGRAMMING;
                    end
                    else
                    begin
                        state_nxt.env = ENV_INTERNAL_RUN;
                    end
                end
                else if (rq.valid)
                begin
                    if (rq.write || rq.erase || rq.mass)
                    begin
                        // Blocked access never reaches the array
                        if (allow)
                        begin
                            state_nxt.flash.valid = 1'b1;
                            state_nxt.flash.write = rq.write;
                            state_nxt.flash.erase = rq.erase;
                            state_nxt.flash.mass = rq.mass;
                            state_nxt.flash.byte_op = rq.byte_op;
                            state_nxt.flash.addr = rq.addr;
                            state_nxt.flash.wdata = rq.wdata;
                        end
                        else
                        begin
                            state_nxt.blocked = 1'b1;
                            state_nxt.blocked_seen = 1'b1;
                        end
                        state_nxt.key_set = 1'b0;
                    end
                    else
                    begin
                        state_nxt.flash.valid = 1'b1;
                        state_nxt.flash.addr = rq.addr;
                    end
                end
            end
            default:
            begin
                state_nxt.st = ST_LOAD_HI;
            end
        endcase
        // Read data follows one cycle after the array read
        if (rd_lock && state_r.env != ENV_INTERNAL_RUN)
        begin
            state_nxt.core_rdata = 16'h0000;
        end
        else
        begin
            state_nxt.core_rdata = i_flash_rdata_w;
        end
        // APB: one wait state, access ends with pready
        if (apb_acc)
        begin
            state_nxt.pready = 1'b1;
            state_nxt.prdata = 32'h0000_0000;
            if (i_pwrite)
            begin
                // Key sticks only on a correct key write
                state_nxt.key_set = key_wr;
                if (i_paddr != OFS_WRITE_KEY)
                begin
                    state_nxt.pslverr = 1'b1;
                end
            end
            else
            begin
                case (i_paddr)
                    OFS_BOOT_CTRL:
                        state_nxt.prdata = {25'd0, state_r.boot_limit};
                    OFS_CODE_CTRL:
                        state_nxt.prdata = {16'd0, state_r.empty, 3'b000,
                            state_r.code_limit};
                    OFS_SEC_CTRL:
                        state_nxt.prdata = {24'd0, state_r.sec};
                    OFS_WRITE_KEY:
                        state_nxt.prdata = KEY_READ;
                    OFS_STATUS:
                        state_nxt.prdata = {26'd0, state_r.blocked_seen,
                            state_r.key_set, wr_sec, rd_sec, state_r.env};
                    default:
                        state_nxt.pslverr = 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register; reset clears key and restarts the load
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= '0;
            state_r.sec <= 8'h00;
            state_r.st <= ST_LOAD_HI;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign o_prdata = state_r.prdata;
    assign o_pready = state_r.pready;
    assign o_pslverr = state_r.pslverr;
    assign o_flash_req = state_r.flash;
    assign o_core_rdata = state_r.core_rdata;
    assign o_core_blocked = state_r.blocked;
    assign o_ready = state_r.ready;
    assign o_env = state_r.env;

endmodule

// ===== hw/fpp_pkg.sv
// Package for the flash program protection block: map, fields, states
package fpp_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_BOOT_CTRL = 8'h00;
    localparam logic [7:0] OFS_CODE_CTRL = 8'h04;
    localparam logic [7:0] OFS_SEC_CTRL = 8'h08;
    localparam logic [7:0] OFS_WRITE_KEY = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Configuration byte addresses in the flash array
    localparam logic [16:0] CFG_CODE_LO = 17'h0_E5FC;
    localparam logic [16:0] CFG_BOOT = 17'h0_E5FD;
    localparam logic [16:0] CFG_CODE_HI = 17'h0_E5FE;
    localparam logic [16:0] CFG_SEC = 17'h0_E5FF;
    localparam logic [16:0] CFG_ODD_LO = 17'h0_E5F9;

    // Address limits of the program range
    localparam logic [16:0] PROG_TOP = 17'h1_FFFF;
    localparam logic [16:0] HOLE_LO = 17'h0_C000;
    localparam logic [16:0] HOLE_HI = 17'h0_FFFF;
    localparam logic [16:0] BLOCK_BYTES = 17'h0_0080;
    localparam logic [16:0] BOOT_TAIL = 17'h0_007F;
    localparam logic [16:0] BOOT_LAST_WORDS = 17'h0_0004;

    // Special field values
    localparam logic [9:0] CODE_OFF = 10'h3FF;
    localparam logic [6:0] BOOT_OFF = 7'h7F;
    localparam logic [7:0] KEY_VALUE = 8'h6A;
    localparam logic [31:0] KEY_READ = 32'h0000_00FF;

    // Field positions
    localparam int CODE_HI_BITS = 2;
    localparam int EMPTY_POS = 13;

    // Environment codes
    typedef enum logic [1:0]
    {
        ENV_INTERNAL_RUN = 2'b00,
        ENV_PROGRAMMING = 2'b01,
        ENV_TEST = 2'b11
    } fpp_env_type;

    // Reset load sequence, Gray along the usual path
    typedef enum logic [2:0]
    {
        ST_LOAD_HI = 3'b000,
        ST_LOAD_SEC = 3'b001,
        ST_LOAD_LO = 3'b011,
        ST_LOAD_BOOT = 3'b010,
        ST_RUN = 3'b110
    } fpp_state_type;

    // Core side program memory request
    typedef struct packed
    {
        logic valid;
        logic write;
        logic erase;
        logic mass;
        logic byte_op;
        logic [16:0] addr;
        logic [15:0] wdata;
        logic [16:0] pc;
    } fpp_req_type;

    // Request forwarded to the flash array
    typedef struct packed
    {
        logic valid;
        logic write;
        logic erase;
        logic mass;
        logic byte_op;
        logic [16:0] addr;
        logic [15:0] wdata;
    } fpp_flash_type;

endpackage

// ===== verification/fpp_properties.sv
// Checker for the ports of fpp_protect
`timescale 1ns/10ps
module fpp_properties
    import fpp_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Core and array
    input wire logic i_test_mode,
    input wire fpp_req_type i_core_req,
    input wire fpp_flash_type o_flash_req,
    input wire logic o_core_blocked,
    input wire logic o_ready
);
    ////////////////////
    logic key_r;
    logic apb_wr;
    logic core_wr;

    // Shadow key: every finished write decides it, erases ignored
    assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
    assign core_wr = o_ready & i_core_req.valid & i_core_req.write;
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            key_r <= 1'b0;
        else if (apb_wr)
            key_r <= (i_paddr == OFS_WRITE_KEY) & (i_pwdata[7:0] == KEY_VALUE);
        else if (core_wr)
            key_r <= 1'b0;
    end

    ////////////////////
    // One clock domain
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    apb_wait_a:
        assert property (i_psel & i_penable & !o_pready |=> o_pready)
        else $error("apb answer missing");
    key_reads_ff_a:
        assert property (o_pready & !i_pwrite & i_paddr == OFS_WRITE_KEY
            |-> o_prdata == KEY_READ) else $error("key read not FF");
    ro_refused_a:
        assert property (o_pready & i_pwrite & i_paddr != OFS_WRITE_KEY
            |-> o_pslverr) else $error("read-only write accepted");
    key_taken_a:
        assert property (o_pready & i_pwrite & i_paddr == OFS_WRITE_KEY
            |-> !o_pslverr) else $error("key write refused");
    keyless_drop_a:
        assert property (core_wr & !key_r & !i_test_mode
            |=> !o_flash_req.valid) else $error("write without key");
    blocked_quiet_a:
        assert property (o_core_blocked |-> !o_flash_req.valid)
        else $error("blocked write reached array");
    ready_hold_a:
        assert property (o_ready |=> o_ready) else $error("reload seen");
    load_first_a:
        assert property ($fell(i_rst) |-> ##[0:2] (o_flash_req.valid
            && o_flash_req.addr == CFG_CODE_HI)) else $error("load order");
    load_done_a:
        assert property ($fell(i_rst) |-> ##[4:9] o_ready)
        else $error("config load slow");

    // Main scenarios
    key_cov: cover property (apb_wr & i_paddr == OFS_WRITE_KEY);
    block_cov: cover property (o_core_blocked);
    write_cov: cover property (o_flash_req.valid & o_flash_req.write);
endmodule

bind fpp_protect fpp_properties u_fpp_properties (.*);

// ===== verification/fpp_flash_model.sv
// Flash array model answering the block's array requests
`timescale 1ns/10ps
module fpp_flash_model
    import fpp_pkg::*;
(
    // Clock, reset and array request
    input wire logic i_clock,
    input wire logic i_rst,
    input wire fpp_flash_type i_req,
    // Config bytes E5FF..E5FC preset by the bench
    input wire logic [31:0] i_cfg,
    // Read data
    output logic [7:0] o_rdata,
    output logic [15:0] o_rdata_w
);
    ////////////////////
    logic rd_hit;
    logic [7:0] noise_r;

    // Config bytes answer within the request cycle: the load sequence
    // takes them at the edge that ends that cycle
    assign rd_hit = i_req.valid & !i_req.write & !i_req.erase &
        (i_req.addr[16:2] == CFG_CODE_LO[16:2]);
    assign o_rdata = rd_hit ? i_cfg[8 * i_req.addr[1:0] +: 8]
        : noise_r;

    // Word data one cycle after a read; its inverse otherwise, never stale
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            noise_r <= 8'h00;
            o_rdata_w <= 16'h0000;
        end
        else
        begin
            noise_r <= ~noise_r;
            if (i_req.valid & !i_req.write & !i_req.erase)
                o_rdata_w <= 16'hA5C3;
            else
                o_rdata_w <= 16'h5A3C;
        end
    end
endmodule

// ===== verification/fpp_protect_bench.sv
// Bench for fpp_protect: registers, key and protection
`timescale 1ns/10ps
module fpp_protect_bench;
    import fpp_pkg::*;
    ////////////////////
    logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_security_override_pin = 1'b0, e;
    logic i_test_mode = 1'b0, o_pready, o_pslverr, o_ready, o_core_blocked;
    logic [7:0] i_paddr = 8'h00, i_flash_rdata, wp = 8'h8D;
    logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, q, sc = 32'hF538_4210;
    logic [31:0] cfg = 32'h0000_0000;
    logic [1:0] i_env_select = 2'b00;
    logic [15:0] i_flash_rdata_w, o_core_rdata;
    fpp_req_type i_core_req = '0, i_pin_req = '0;
    fpp_flash_type o_flash_req;
    fpp_env_type o_env;
    int err_count = 0, n_tests = 0, i;
    logic [16:0] wa [8] = '{17'h0_7FFE, 17'h0_8000, 17'h0_C000, 17'h0_FFFE,
        17'h1_0000, 17'h1_FFFE, 17'h0_00FE, 17'h0_0100};

    // Design, array model and the 250 MHz clock
    fpp_protect u_fpp_protect (.*);
    fpp_flash_model u_fpp_flash_model (.i_clock(i_clock), .i_rst(i_rst),
        .i_req(o_flash_req), .i_cfg(cfg), .o_rdata(i_flash_rdata),
        .o_rdata_w(i_flash_rdata_w));
    initial
    begin
        forever #2 i_clock = ~i_clock;
    end

    ////////////////////
    // Compare and verdict
    task automatic check(input string nm, input logic [31:0] s,
        input logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait; running out ends the run as a mismatch
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (s !== 1'b1 && n < 40);
        if (s !== 1'b1)
        begin
            check("wait", 1'b0, 1'b1);
            print_verdict();
        end
    endtask

    ////////////////////
    // APB transfer held until pready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        wait_hi(o_pready);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        check("register", q, x);
    endtask
    // k keys, then one core access; x says whether a write reaches the array or read data returns
    task automatic op(input int k, input logic w, input logic [16:0] a,
        input logic [16:0] pc, input logic x);
        logic saw;
        logic blk;
        saw = 1'b0;
        blk = 1'b0;
        repeat (k) apb(1'b1, OFS_WRITE_KEY, 32'h0000_006A);
        // Never erases a config page, so no page words to save
        i_core_req <= '{1'b1, w, 1'b0, 1'b0, 1'b1, a, 16'h1234, pc};
        @(posedge i_clock);
        i_core_req.valid <= 1'b0;
        repeat (6)
        begin
            @(posedge i_clock);
            if (w ? (o_flash_req.valid === 1'b1 && o_flash_req.write === 1'b1)
                : (o_core_rdata === 16'hA5C3))
                saw = 1'b1;
            if (o_core_blocked === 1'b1)
                blk = 1'b1;
        end
        check(w ? "array write" : "read data", saw, x);
        check("blocked", blk, w & !x);
    endtask
    // Reset with new config bytes {E5FF, E5FE, E5FD, E5FC}
    task automatic boot(input logic [31:0] c, input logic [1:0] es,
        input logic ov);
        cfg <= c;
        i_env_select <= es;
        i_security_override_pin <= ov;
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        wait_hi(o_ready);
    endtask

    ////////////////////
    // Scenarios
    initial
    begin
        boot(32'hFF01_0100, 2'b00, 1'b0);
        check("env", o_env, ENV_INTERNAL_RUN);
        rd(OFS_BOOT_CTRL, 32'h0000_0001);
        rd(OFS_CODE_CTRL, 32'h0000_0100);
        rd(OFS_WRITE_KEY, KEY_READ);
        rd(OFS_STATUS, 32'h0000_0000);
        apb(1'b1, OFS_SEC_CTRL, 32'h0000_0000);
        check("refused", e, 1'b1);
        rd(OFS_SEC_CTRL, 32'h0000_00FF);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped", e, 1'b1);
        for (i = 0; i < 8; i++)
            op(1, 1'b1, wa[i], 17'h0_0400, wp[i]);
        op(0, 1'b1, 17'h0_0200, 17'h0_0400, 1'b0);
        op(1, 1'b1, 17'h0_0200, 17'h0_0400, 1'b1);
        op(0, 1'b1, 17'h0_0202, 17'h0_0400, 1'b0);
        apb(1'b1, OFS_WRITE_KEY, 32'h0000_006A);
        apb(1'b1, OFS_BOOT_CTRL, 32'h0000_0000);
        op(0, 1'b1, 17'h0_0200, 17'h0_0400, 1'b0);
        apb(1'b1, OFS_WRITE_KEY, 32'h0000_006B);
        op(0, 1'b1, 17'h0_0200, 17'h0_0400, 1'b0);
        op(2, 1'b1, 17'h0_0200, 17'h0_0400, 1'b1);
        op(1, 1'b1, CFG_CODE_LO, 17'h0_0400, 1'b0);
        op(1, 1'b1, CFG_CODE_LO, 17'h0_0010, 1'b1);
        op(1, 1'b1, CFG_CODE_LO, 17'h0_00FC, 1'b0);
        op(1, 1'b1, CFG_BOOT, 17'h0_0010, 1'b0);
        // Both limits off
        boot(32'hFF03_7FFF, 2'b00, 1'b0);
        op(1, 1'b1, CFG_CODE_LO, 17'h0_0010, 1'b0);
        op(1, 1'b1, 17'h1_FFFE, 17'h0_0400, 1'b1);
        op(1, 1'b1, 17'h0_0000, 17'h0_0400, 1'b1);
        // Blank array, pins high, write security on
        boot(32'h0F61_7FFF, 2'b11, 1'b0);
        check("env", o_env, ENV_PROGRAMMING);
        op(1, 1'b1, 17'h0_0200, 17'h0_0400, 1'b0);
        rd(OFS_STATUS, 32'h0000_0029);
        i_security_override_pin <= 1'b1;
        op(1, 1'b1, 17'h0_0200, 17'h0_0400, 1'b1);
        // Read security codes outside internal run
        for (i = 0; i < 8; i++)
        begin
            boot({4'hF, sc[4 * i +: 4], 24'hA1_7FFF}, 2'b11, 1'b0);
            op(0, 1'b0, 17'h0_0200, 17'h0_0400, i > 4);
        end
        boot(32'hF0A1_7FFF, 2'b10, 1'b0);
        check("env", o_env, ENV_INTERNAL_RUN);
        op(0, 1'b0, 17'h0_0200, 17'h0_0400, 1'b1);
        boot(32'hF0A1_7FFF, 2'b11, 1'b1);
        op(0, 1'b0, 17'h0_0200, 17'h0_0400, 1'b1);
        // Pins drive the array in test mode, core bypassed
        i_test_mode <= 1'b1;
        boot(32'hFF03_7FFF, 2'b00, 1'b0);
        check("env", o_env, ENV_TEST);
        apb(1'b1, OFS_WRITE_KEY, 32'h0000_006A);
        i_pin_req <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 17'h0_0300,
            16'h1234, 17'h0_0000};
        @(posedge i_clock);
        i_pin_req.valid <= 1'b0;
        @(posedge i_clock);
        check("pin write", {o_flash_req.valid, o_flash_req.addr},
            {1'b1, 17'h0_0300});
        print_verdict();
    end
endmodule
